// file: dv/speres_link_model.sv
/*
 Link-side partner: drives live link state and one-cycle events into the
 register. Assumes bench requests change just after a rising ref_clk edge.
*/
`timescale 1ns/1ps
module speres_link_model
	import speres_pkg::*;
(
	input  wire logic          ref_clk, // Register clock
	input  wire logic          rst,     // Async reset, active high
	input  wire speres_state_s st_req,  // Requested link state
	input  wire speres_event_s ev_req,  // Requested event pulses
	output speres_state_s      link_st, // Live state to register
	output speres_event_s      link_ev  // Event pulses to register
);
	// Registered, so every change lands one edge late, as real link logic would
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			link_st <= '0;
			link_ev <= '0;
		end else begin
			link_st <= st_req;
			link_ev <= ev_req;
		end
	end
endmodule : speres_link_model

// file: dv/tb_speres_reg.sv
/*
 Self-checking bench for the port error and status register.
 Assumes the link model file is compiled before it and the package before both.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; $display("wrong value at %0t: %h not %h", $time, a, b); end end
module tb_speres_reg
	import speres_pkg::*;
;
	localparam logic [11:0] OFS  = PORT_ERROR_AND_STATUS_OFFSET;
	localparam logic [31:0] BASE = 32'h9000_0001;          // Support, unavailable, uninitialised
	localparam int          EVB[6] = '{29, 27, -1, 7, 6, 5}; // Status bit per event field, lsb first
	logic          ref_clk = 1'h0;
	logic          rst = 1'h1;
	logic          wr = 1'h0;
	logic          rd = 1'h0;
	logic [11:0]   addr = 12'h000;
	logic [31:0]   wdata = 32'h0000_0000;
	logic [31:0]   rdata;
	logic          idle2_en;
	logic          irq;
	logic [31:0]   rdata_o;    // Only-alternate-idle instance, no port-writes
	logic [31:0]   rdata_n;    // Instance without alternate idle support
	logic          idle2_en_o;
	logic          idle2_en_n;
	speres_state_s st_req = '0;
	speres_state_s link_st;
	speres_event_s ev_req = '0;
	speres_event_s link_ev;
	int            fails = 0;
	int            cmp_count = 0;
	int            cyc = 0;

	// 40 MHz clock
	always #12.5 ref_clk = ~ref_clk;

	speres_link_model speres_link_model_i (.ref_clk(ref_clk), .rst(rst), .st_req(st_req), .ev_req(ev_req),
		.link_st(link_st), .link_ev(link_ev));
	speres_reg #(.PORT_UNAVAIL(1'h1)) speres_reg_i (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .link_st(link_st), .link_ev(link_ev), .idle2_en(idle2_en), .irq(irq));
	speres_reg #(.IDLE2_ONLY(1'h1), .PW_SUPPORTED(1'h0)) speres_reg_only_i (.ref_clk(ref_clk), .rst(rst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata_o), .link_st(link_st), .link_ev(link_ev),
		.idle2_en(idle2_en_o), .irq());
	speres_reg #(.IDLE2_SUPPORTED(1'h0)) speres_reg_nosup_i (.ref_clk(ref_clk), .rst(rst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata_n), .link_st(link_st), .link_ev(link_ev),
		.idle2_en(idle2_en_n), .irq());

	task final_report;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : final_report

	// Bus cycles: strobe held for exactly one sampling edge
	task wr_reg(input logic [11:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		wr <= 1'h1;
		addr <= a;
		wdata <= v;
		@(posedge ref_clk);
		wr <= 1'h0;
	endtask : wr_reg

	task rd_chk(input logic [11:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		rd <= 1'h1;
		addr <= a;
		@(posedge ref_clk);
		rd <= 1'h0;
		#1 `CHK(rdata, exp)
	endtask : rd_chk

	task pulse(input speres_event_s e);
		@(posedge ref_clk);
		ev_req <= e;
		@(posedge ref_clk);
		ev_req <= '0;
	endtask : pulse

	task set_state(input speres_state_s s);
		@(posedge ref_clk);
		st_req <= s;
		repeat (3) @(posedge ref_clk);
	endtask : set_state

	task t_reset;
		rd_chk(OFS, BASE);
		`CHK(idle2_en, 1'h0)
	endtask : t_reset

	// Each event sets its flag; zero and read-only writes leave it; a one clears it
	task t_events;
		logic [31:0] m;
		for (int i = 0; i < 6; i++) begin
			if (EVB[i] >= 0) begin
				m = 32'h0000_0001 << EVB[i];
				pulse(speres_event_s'(6'h01 << i));
				rd_chk(OFS, BASE | m);
				wr_reg(OFS, ~(STICKY_MASK | 32'h0000_0002));
				rd_chk(OFS, BASE | m);
				wr_reg(OFS, m);
				rd_chk(OFS, BASE);
			end
		end
		`CHK(irq, 1'h0)
	endtask : t_events

	// Drop event and clearing write hit the same edge: the set must win
	task t_collide;
		@(posedge ref_clk);
		ev_req <= speres_event_s'(6'h20);
		@(posedge ref_clk);
		ev_req <= '0;
		wr <= 1'h1;
		addr <= OFS;
		wdata <= 32'h0000_0020;
		@(posedge ref_clk);
		wr <= 1'h0;
		rd_chk(OFS, BASE | 32'h0000_0020);
		wr_reg(OFS, 32'h0000_0020);
	endtask : t_collide

	task t_retry;
		set_state(speres_state_s'(6'h10));
		rd_chk(OFS, BASE | 32'h0000_3800);
		pulse(speres_event_s'(6'h04));
		rd_chk(OFS, BASE | 32'h0000_2800);
		set_state('0);
		rd_chk(OFS, BASE | 32'h0000_0800);
		wr_reg(OFS, 32'h0000_0800);
	endtask : t_retry

	task t_states;
		set_state(speres_state_s'(6'h2F));
		rd_chk(OFS, 32'h50E0_C005);
		set_state('0);
		rd_chk(OFS, 32'h9040_4001);
		wr_reg(OFS, 32'h0040_4000);
	endtask : t_states

	task t_enable;
		wr_reg(OFS, 32'hFFFF_FFFF);
		rd_chk(OFS, BASE | 32'h0000_0002);
		`CHK(idle2_en, 1'h1)
		wr_reg(OFS, 32'h0000_0000);
		rd_chk(OFS, BASE);
		rd_chk(12'h100, 32'h0000_0000);
	endtask : t_enable

	// Read clears interrupt status; only unmasked flags raise the line
	task t_irq;
		rd_chk(IRQ_STATUS_OFFSET, 32'h2840_48E0);
		rd_chk(IRQ_STATUS_OFFSET, 32'h0000_0000);
		wr_reg(IRQ_MASK_OFFSET, 32'h0000_0020);
		rd_chk(IRQ_MASK_OFFSET, 32'h0000_0020);
		pulse(speres_event_s'(6'h08));
		repeat (3) @(posedge ref_clk);
		`CHK(irq, 1'h0)
		pulse(speres_event_s'(6'h20));
		repeat (3) @(posedge ref_clk);
		`CHK(irq, 1'h1)
		rd_chk(IRQ_STATUS_OFFSET, 32'h0000_00A0);
		repeat (2) @(posedge ref_clk);
		`CHK(irq, 1'h0)
	endtask : t_irq

	// Configuration variants: refused enable writes, port-write support, fixed bits
	task t_config;
		pulse(speres_event_s'(6'h02));
		rd_chk(OFS, BASE | 32'h0800_0000);
		`CHK(rdata_o, 32'h8000_0003)
		`CHK(rdata_n, 32'h8800_0000)
		wr_reg(OFS, 32'hFFFF_FFFF);
		rd_chk(OFS, BASE | 32'h0000_0002);
		`CHK(rdata_n, 32'h8000_0000)
		`CHK(idle2_en_n, 1'h0)
		wr_reg(OFS, 32'h0000_0000);
		rd_chk(OFS, BASE);
		`CHK(rdata_o, 32'h8000_0003)
		`CHK(idle2_en_o, 1'h1)
	endtask : t_config

	// Reset in mid-run drops flags, mask and interrupt
	task t_midreset;
		pulse(speres_event_s'(6'h20));
		repeat (2) @(posedge ref_clk);
		`CHK(irq, 1'h1)
		rst <= 1'h1;
		repeat (3) @(posedge ref_clk);
		rst <= 1'h0;
		`CHK(irq, 1'h0)
		rd_chk(OFS, BASE);
		rd_chk(IRQ_MASK_OFFSET, 32'h0000_0000);
		`CHK(idle2_en_o, 1'h1)
	endtask : t_midreset

	// Main sequence after three cycles of reset
	initial begin
		repeat (3) @(posedge ref_clk);
		rst <= 1'h0;
		t_reset;
		t_events;
		t_collide;
		t_retry;
		t_states;
		t_enable;
		t_config;
		t_irq;
		t_midreset;
		final_report;
	end

	// Run needs about 160 cycles; the ceiling leaves ample margin
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			final_report;
		end
	end
endmodule : tb_speres_reg

// file: rtl/speres_pkg.sv
/*
 Package for the port error and status register: offset, bit positions, reset
 values and the carrier structs between the link logic and the register.
 Assumes a single register clock domain and a plain address/strobe port.
*/
package speres_pkg;

	localparam logic [11:0] PORT_ERROR_AND_STATUS_OFFSET = 12'h158;
	localparam logic [11:0] IRQ_STATUS_OFFSET            = 12'h160;
	localparam logic [11:0] IRQ_MASK_OFFSET              = 12'h164;

	localparam int BIT_IDLE2_SUPPORT  = 0;
	localparam int BIT_IDLE2_ENABLE   = 1;
	localparam int BIT_IDLE_ACTIVE    = 2;
	localparam int BIT_PKT_DROPPED    = 5;
	localparam int BIT_FAILED_ENC     = 6;
	localparam int BIT_DEGRADED_ENC   = 7;
	localparam int BIT_RETRY_ENC      = 11;
	localparam int BIT_RETRIED        = 12;
	localparam int BIT_RETRY_STOPPED  = 13;
	localparam int BIT_OUT_ERR_ENC    = 14;
	localparam int BIT_OUT_ERR_STOP   = 15;
	localparam int BIT_IN_RETRY_STOP  = 21;
	localparam int BIT_IN_ERR_ENC     = 22;
	localparam int BIT_IN_ERR_STOP    = 23;
	localparam int BIT_PW_PENDING     = 27;
	localparam int BIT_UNAVAILABLE    = 28;
	localparam int BIT_PORT_ERROR     = 29;
	localparam int BIT_PORT_OK        = 30;
	localparam int BIT_UNINIT         = 31;

	// Sticky bits cleared by writing one, plus the bit 23 live mirror, which has no flag
	localparam logic [31:0] STICKY_MASK   = 32'h28C0_48E0;
	localparam logic [31:0] RESERVED_MASK = 32'h071F_0718; // Reserved fields, always read zero
	localparam logic        IDLE_RST      = 1'h0;
	localparam logic        UNINIT_RST    = 1'h1;
	localparam logic [31:0] STICKY_RST    = 32'h0000_0000;
	localparam logic [31:0] IRQ_MASK_RST  = 32'h0000_0000;

	// Live link state feeding the register
	typedef struct packed {
		logic idle_active;
		logic out_retry_stopped;
		logic out_error_stopped;
		logic in_retry_stopped;
		logic in_error_stopped;
		logic port_ok;
	} speres_state_s;

	// One-cycle link events
	typedef struct packed {
		logic pkt_dropped;
		logic failed_thresh;
		logic degraded_thresh;
		logic ack_received;
		logic pw_required;
		logic unrecoverable;
	} speres_event_s;

endpackage : speres_pkg

// file: rtl/speres_reg.sv
/*
 Port error and status register with sticky flags, live state mirror and a
 masked interrupt. Assumes link inputs come from logic on ref_clk, so they are
 not synchronised, and that the bus master never issues read and write together.
*/
// Operation
// - Bit 0 reads the configured alternate idle support, read only.
// - Bit 1 enables alternate idle; illegal settings against support are refused.
// - Bit 2 shows the active idle sequence, reset zero.
// - Bit 5 sticks on a dropped output packet until written one.
// - Bit 6 sticks on reaching the failed threshold until written one.
// - Bit 7 sticks on reaching the degraded threshold until written one.
// - Bit 11 sticks when retry-stopped rises until written one.
// - Bit 13 mirrors output retry-stopped state.
// - Bit 12 sets with bit 13, clears on accepted or not-accepted symbol.
// - Bit 15 mirrors output error-stopped; bit 14 sticks on its rise.
// - Bit 21 mirrors input retry-stopped, reset zero.
// - Bit 23 mirrors input error-stopped; bit 22 sticks on its rise.
// - Bit 27 sticks when a port-write is required, if supported.
// - Bit 28 reads configured port-unavailable value.
// - Bit 29 sticks on an unrecoverable error until written one.
// - Bit 30 high only while initialised and error free, reset zero.
// - Bit 31 high while uninitialised, resets one, never with bit 30.
`timescale 1ns/1ps
module speres_reg
	import speres_pkg::*;
#(
	parameter logic IDLE2_SUPPORTED = 1'h1, // Alternate idle supported
	parameter logic IDLE2_ONLY      = 1'h0, // Only alternate idle supported
	parameter logic IDLE2_EN_RST    = 1'h0, // Enable value after reset
	parameter logic PW_SUPPORTED    = 1'h1, // Port-write issuing supported
	parameter logic PORT_UNAVAIL    = 1'h0  // Port merged into a wider link
) (
	input  wire logic          ref_clk,   // 40 MHz register clock
	input  wire logic          rst,       // Async reset, active high
	input  wire logic [11:0]   addr,      // Byte address
	input  wire logic [31:0]   wdata,     // Write data
	input  wire logic          wr,        // Write strobe
	input  wire logic          rd,        // Read strobe
	output logic      [31:0]   rdata,     // Read data, cycle after rd
	input  wire speres_state_s link_st,   // Live link state
	input  wire speres_event_s link_ev,   // One-cycle link events
	output logic               idle2_en,  // Alternate idle enable to link
	output logic               irq        // Level interrupt
);

	logic [31:0]   sticky_r;
	logic          idle2_en_r;
	logic          retried_r;
	speres_state_s st_d_r;
	logic [31:0]   irq_stat_r;
	logic [31:0]   irq_mask_r;
	logic [31:0]   set_vec;
	logic [31:0]   live;
	logic          wr_pes;
	logic          rd_pes;

	// Single word decode shared by write and read paths
	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		return a == off;
	endfunction : hit

	assign wr_pes = wr && hit(addr, PORT_ERROR_AND_STATUS_OFFSET);
	assign rd_pes = rd && hit(addr, PORT_ERROR_AND_STATUS_OFFSET);

	// Previous state for rising-edge detection of stopped states
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_d_r <= '0;
		end else begin
			st_d_r <= link_st;
		end
	end

	// Hardware set sources, one bit per sticky flag
	always_comb begin
		set_vec                   = '0;
		set_vec[BIT_PKT_DROPPED]  = link_ev.pkt_dropped;
		set_vec[BIT_FAILED_ENC]   = link_ev.failed_thresh;
		set_vec[BIT_DEGRADED_ENC] = link_ev.degraded_thresh;
		set_vec[BIT_RETRY_ENC]    = link_st.out_retry_stopped && !st_d_r.out_retry_stopped;
		set_vec[BIT_OUT_ERR_ENC]  = link_st.out_error_stopped && !st_d_r.out_error_stopped;
		set_vec[BIT_IN_ERR_ENC]   = link_st.in_error_stopped && !st_d_r.in_error_stopped;
		set_vec[BIT_PW_PENDING]   = link_ev.pw_required && PW_SUPPORTED;
		set_vec[BIT_PORT_ERROR]   = link_ev.unrecoverable;
	end

	// Sticky flags: write one clears, set wins over a same-cycle clear
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sticky_r <= STICKY_RST;
		end else begin
			sticky_r <= ((sticky_r & ~(wr_pes ? (wdata & STICKY_MASK) : 32'h0000_0000)) | set_vec)
				& STICKY_MASK;
		end
	end

	// Retried: set with retry-stopped, cleared by an acknowledge symbol
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			retried_r <= 1'h0;
		end else if (link_st.out_retry_stopped && !st_d_r.out_retry_stopped) begin
			retried_r <= 1'h1;
		end else if (link_ev.ack_received) begin
			retried_r <= 1'h0;
		end
	end

	// Idle enable refuses writes the configured support cannot honour
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			idle2_en_r <= IDLE2_SUPPORTED & (IDLE2_EN_RST | IDLE2_ONLY); // Forced on when only alternate idle exists
		end else if (!IDLE2_SUPPORTED) begin
			idle2_en_r <= 1'h0;
		end else if (IDLE2_ONLY) begin
			idle2_en_r <= 1'h1;
		end else if (wr_pes) begin
			idle2_en_r <= wdata[BIT_IDLE2_ENABLE];
		end
	end
	assign idle2_en = idle2_en_r;

	// Read view; reserved bits stay zero
	always_comb begin
		live                     = '0;
		live                     = sticky_r;
		live[BIT_IDLE2_SUPPORT]  = IDLE2_SUPPORTED;
		live[BIT_IDLE2_ENABLE]   = idle2_en_r;
		live[BIT_IDLE_ACTIVE]    = link_st.idle_active;
		live[BIT_RETRIED]        = retried_r;
		live[BIT_RETRY_STOPPED]  = link_st.out_retry_stopped;
		live[BIT_OUT_ERR_STOP]   = link_st.out_error_stopped;
		live[BIT_IN_RETRY_STOP]  = link_st.in_retry_stopped;
		live[BIT_IN_ERR_STOP]    = link_st.in_error_stopped;
		live[BIT_UNAVAILABLE]    = PORT_UNAVAIL;
		live[BIT_PORT_OK]        = link_st.port_ok && !rst;
		live[BIT_UNINIT]         = !(link_st.port_ok && !rst);
	end

	// Interrupt status mirrors sticky sets; a read of it clears, set still wins
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			irq_stat_r <= STICKY_RST;
		end else begin
			irq_stat_r <= ((rd && hit(addr, IRQ_STATUS_OFFSET)) ? 32'h0000_0000 : irq_stat_r) | set_vec;
		end
	end

	// Mask register, same layout as status
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			irq_mask_r <= IRQ_MASK_RST;
		end else if (wr && hit(addr, IRQ_MASK_OFFSET)) begin
			irq_mask_r <= wdata & STICKY_MASK;
		end
	end

	assign irq = |(irq_stat_r & irq_mask_r);

	// Read data registered one cycle after the strobe, zero otherwise
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdata <= 32'h0000_0000;
		end else if (rd) begin
			if (hit(addr, PORT_ERROR_AND_STATUS_OFFSET)) begin
				rdata <= live;
			end else if (hit(addr, IRQ_STATUS_OFFSET)) begin
				rdata <= irq_stat_r;
			end else if (hit(addr, IRQ_MASK_OFFSET)) begin
				rdata <= irq_mask_r;
			end else begin
				rdata <= 32'h0000_0000;
			end
		end else begin
			rdata <= 32'h0000_0000;
		end
	end

	// Sticky bit must follow a rising output error-stopped state
	property p_out_err_sticky;
		@(posedge ref_clk) disable iff (rst)
		$rose(link_st.out_error_stopped) |=> sticky_r[BIT_OUT_ERR_ENC];
	endproperty
	a_out_err_sticky: assert property (p_out_err_sticky) else $error("output error flag not set");

	property p_in_err_sticky;
		@(posedge ref_clk) disable iff (rst)
		$rose(link_st.in_error_stopped) |=> sticky_r[BIT_IN_ERR_ENC];
	endproperty
	a_in_err_sticky: assert property (p_in_err_sticky) else $error("input error flag not set");

	property p_retry_sticky;
		@(posedge ref_clk) disable iff (rst)
		$rose(link_st.out_retry_stopped) |=> sticky_r[BIT_RETRY_ENC] && retried_r;
	endproperty
	a_retry_sticky: assert property (p_retry_sticky) else $error("retry flags not set");

	property p_drop_hold;
		@(posedge ref_clk) disable iff (rst)
		sticky_r[BIT_PKT_DROPPED] && !(wr_pes && wdata[BIT_PKT_DROPPED]) |=> sticky_r[BIT_PKT_DROPPED];
	endproperty
	a_drop_hold: assert property (p_drop_hold) else $error("dropped flag lost");

	property p_set_wins;
		@(posedge ref_clk) disable iff (rst)
		wr_pes && (set_vec & wdata) != 32'h0000_0000 |=> (sticky_r & $past(set_vec)) == $past(set_vec);
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("clear beat a set");

	property p_ok_excl;
		@(posedge ref_clk) disable iff (rst)
		rd && hit(addr, PORT_ERROR_AND_STATUS_OFFSET) |=> rdata[BIT_PORT_OK] != rdata[BIT_UNINIT];
	endproperty
	a_ok_excl: assert property (p_ok_excl) else $error("ok and uninit together");

	property p_reserved;
		@(posedge ref_clk) disable iff (rst)
		rd |=> (rdata & RESERVED_MASK) == 32'h0000_0000;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit read non-zero");

	property p_ack_clear;
		@(posedge ref_clk) disable iff (rst)
		link_ev.ack_received && !$rose(link_st.out_retry_stopped) |=> !retried_r;
	endproperty
	a_ack_clear: assert property (p_ack_clear) else $error("retried not cleared");

	property p_idle_refuse;
		@(posedge ref_clk) disable iff (rst)
		!IDLE2_SUPPORTED |-> !idle2_en_r;
	endproperty
	a_idle_refuse: assert property (p_idle_refuse) else $error("idle enable set without support");

	// Support bit always reads the configured value
	property p_support_bit;
		@(posedge ref_clk) disable iff (rst)
		rd_pes |=> rdata[BIT_IDLE2_SUPPORT] == IDLE2_SUPPORTED;
	endproperty
	a_support_bit: assert property (p_support_bit) else $error("idle support bit wrong");

	// A legal enable write lands in the next cycle
	property p_idle_write;
		@(posedge ref_clk) disable iff (rst)
		wr_pes && IDLE2_SUPPORTED && !IDLE2_ONLY |=> idle2_en_r == $past(wdata[BIT_IDLE2_ENABLE]);
	endproperty
	a_idle_write: assert property (p_idle_write) else $error("idle enable write lost");

	// Only-alternate ports can never turn the enable off, not even by reset
	property p_idle_only;
		@(posedge ref_clk) disable iff (rst)
		IDLE2_SUPPORTED && IDLE2_ONLY |-> idle2_en_r;
	endproperty
	a_idle_only: assert property (p_idle_only) else $error("idle enable cleared on only-alternate port");

	// Active idle bit shows the link state at the read strobe
	property p_idle_view;
		@(posedge ref_clk) disable iff (rst)
		rd_pes |=> rdata[BIT_IDLE_ACTIVE] == $past(link_st.idle_active);
	endproperty
	a_idle_view: assert property (p_idle_view) else $error("active idle bit wrong");

	// Dropped packet event is never missed
	property p_drop_set;
		@(posedge ref_clk) disable iff (rst)
		link_ev.pkt_dropped |=> sticky_r[BIT_PKT_DROPPED];
	endproperty
	a_drop_set: assert property (p_drop_set) else $error("dropped flag not set");

	// Failed threshold event is never missed
	property p_failed_set;
		@(posedge ref_clk) disable iff (rst)
		link_ev.failed_thresh |=> sticky_r[BIT_FAILED_ENC];
	endproperty
	a_failed_set: assert property (p_failed_set) else $error("failed flag not set");

	// Degraded threshold event is never missed
	property p_degraded_set;
		@(posedge ref_clk) disable iff (rst)
		link_ev.degraded_thresh |=> sticky_r[BIT_DEGRADED_ENC];
	endproperty
	a_degraded_set: assert property (p_degraded_set) else $error("degraded flag not set");

	// Retry flag survives anything but a write of one
	property p_retry_hold;
		@(posedge ref_clk) disable iff (rst)
		sticky_r[BIT_RETRY_ENC] && !(wr_pes && wdata[BIT_RETRY_ENC]) |=> sticky_r[BIT_RETRY_ENC];
	endproperty
	a_retry_hold: assert property (p_retry_hold) else $error("retry flag lost");

	// Retry-stopped bit is a live mirror
	property p_retry_view;
		@(posedge ref_clk) disable iff (rst)
		rd_pes |=> rdata[BIT_RETRY_STOPPED] == $past(link_st.out_retry_stopped);
	endproperty
	a_retry_view: assert property (p_retry_view) else $error("retry-stopped bit wrong");

	// Retried stays up until an acknowledge symbol arrives
	property p_retried_hold;
		@(posedge ref_clk) disable iff (rst)
		retried_r && !link_ev.ack_received |=> retried_r;
	endproperty
	a_retried_hold: assert property (p_retried_hold) else $error("retried dropped early");

	// Output error-stopped bit is a live mirror
	property p_out_err_view;
		@(posedge ref_clk) disable iff (rst)
		rd_pes |=> rdata[BIT_OUT_ERR_STOP] == $past(link_st.out_error_stopped);
	endproperty
	a_out_err_view: assert property (p_out_err_view) else $error("output error-stopped bit wrong");

	// Input retry-stopped bit is a live mirror
	property p_in_retry_view;
		@(posedge ref_clk) disable iff (rst)
		rd_pes |=> rdata[BIT_IN_RETRY_STOP] == $past(link_st.in_retry_stopped);
	endproperty
	a_in_retry_view: assert property (p_in_retry_view) else $error("input retry-stopped bit wrong");

	// Input error-stopped bit is a live mirror
	property p_in_err_view;
		@(posedge ref_clk) disable iff (rst)
		rd_pes |=> rdata[BIT_IN_ERR_STOP] == $past(link_st.in_error_stopped);
	endproperty
	a_in_err_view: assert property (p_in_err_view) else $error("input error-stopped bit wrong");

	// Port-write pending follows the request only where port-writes exist
	property p_pw_set;
		@(posedge ref_clk) disable iff (rst)
		link_ev.pw_required |=> sticky_r[BIT_PW_PENDING] == PW_SUPPORTED;
	endproperty
	a_pw_set: assert property (p_pw_set) else $error("port-write flag wrong");

	// Unavailable bit always reads the configured value
	property p_unavail;
		@(posedge ref_clk) disable iff (rst)
		rd_pes |=> rdata[BIT_UNAVAILABLE] == PORT_UNAVAIL;
	endproperty
	a_unavail: assert property (p_unavail) else $error("unavailable bit wrong");

	// Unrecoverable error event is never missed
	property p_port_err_set;
		@(posedge ref_clk) disable iff (rst)
		link_ev.unrecoverable |=> sticky_r[BIT_PORT_ERROR];
	endproperty
	a_port_err_set: assert property (p_port_err_set) else $error("port error flag not set");

	// Port OK follows the link at the read strobe
	property p_ok_view;
		@(posedge ref_clk) disable iff (rst)
		rd_pes |=> rdata[BIT_PORT_OK] == $past(link_st.port_ok);
	endproperty
	a_ok_view: assert property (p_ok_view) else $error("port ok bit wrong");

	// Uninitialised is the inverse of port OK
	property p_uninit_view;
		@(posedge ref_clk) disable iff (rst)
		rd_pes |=> rdata[BIT_UNINIT] == !$past(link_st.port_ok);
	endproperty
	a_uninit_view: assert property (p_uninit_view) else $error("uninitialised bit wrong");

	// Nothing on the read bus outside the cycle after a strobe
	property p_rdata_idle;
		@(posedge ref_clk) disable iff (rst)
		!rd |=> rdata == 32'h0000_0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle");

	// Writing zero never clears a set flag
	property p_zero_write;
		@(posedge ref_clk) disable iff (rst)
		wr_pes |=> ($past(sticky_r) & ~$past(wdata) & ~sticky_r) == 32'h0000_0000;
	endproperty
	a_zero_write: assert property (p_zero_write) else $error("zero write cleared a flag");

	// An unmasked event raises the line in the next cycle
	property p_irq_raise;
		@(posedge ref_clk) disable iff (rst)
		(set_vec & irq_mask_r) != 32'h0000_0000 && !(wr && hit(addr, IRQ_MASK_OFFSET)) |=> irq;
	endproperty
	a_irq_raise: assert property (p_irq_raise) else $error("interrupt not raised");

endmodule : speres_reg
